// *** tcfl_defines.vh ***
// constants for the per-thread trace cache fill and lookup block
// assumes inclusion by bare name from every design file
`ifndef TCFL_DEFINES_VH
`define TCFL_DEFINES_VH
`define TCFL_ADDR_W      32
`define TCFL_UOP_W       32
`define TCFL_MAX_UOPS    16
`define TCFL_UCNT_W      5
`define TCFL_MAX_BR      3
`define TCFL_BCNT_W      2
`define TCFL_TQ_DEPTH    32
`define TCFL_TQ_AW       5
`define TCFL_CF_DEPTH    4
`define TCFL_CF_AW       2
`define TCFL_SETS        64
`define TCFL_SET_W       6
`define TCFL_WAYS        4
`define TCFL_WAY_W       2
`define TCFL_LINES       256
`define TCFL_LINE_W      8
`define TCFL_UMEM        4096
`define TCFL_ST_IDLE     1'b0
`define TCFL_ST_STREAM   1'b1
`endif

// *** tcfl_top.v ***
// per-thread trace cache: post-commit fill unit, fetch-side lookup,
// commit-side input FIFO and trace queue toward decode
// assumes commit, fetch and predictor logic on the same clk; one
// instance per hardware thread
//
// Operation
// - a stored trace holds at most sixteen micro-instructions
// - one macro stays in one trace; oversized macros never stored
// - a trace holds at most three branches
// - trace queue toward decode holds thirty-two micro-instructions
// - each line has valid bit and tag of its first uop address
// - branch total excludes a final branch uop
// - each line has direction bits and a direction-valid mask
// - traces are built only from committed instructions
// - temporary trace dumped when uop or branch limit is hit
// - first instruction into an empty trace gives the tag
// - branch records sequential-next and taken-target addresses
// - branch sets direction and mask bit, bumps both counters
// - non-branch updates sequential-next, clears target, bumps uops
// - fit check before append; dump to new line if no fit
// - dump with nonzero target drops last direction bit and count
// - a hit feeds the trace, otherwise instruction cache fetch
// - lines indexed by fetch pointer; ways differ by directions
// - hit when prediction masked by line mask equals directions
// - hit with zero target fetches next from sequential-next
// - hit with target picks next address by following prediction bit
// - each hardware thread owns a private instance of this cache
// - no lookup in a cycle when the trace queue is full
// - count each lookup cycle as access and each match as hit
// - cache works only when enabled; disabled means icache fetch; fill unit still builds and stores traces when disabled
// - geometry sixty-four sets by four ways
`timescale 1ns/10ps
`include "tcfl_defines.vh"

// ----------------------------------------------------------------
// small synchronous fifo with registered full and empty
// ----------------------------------------------------------------
module tcfl_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk,       // core clock
    input  wire             rst,       // async reset, high
    input  wire             in_valid,  // producer has a word
    output wire             in_ready,  // room for a word
    input  wire [WIDTH-1:0] in_data,   // word in
    output wire             out_valid, // word available
    input  wire             out_ready, // consumer takes it
    output wire [WIDTH-1:0] out_data   // oldest word
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp_r;
    reg [AW-1:0]    rp_r;
    reg [AW:0]      cnt_r;
    reg             full_r;
    reg             empty_r;
    wire            push;
    wire            pop;
    reg  [AW:0]     cnt_nxt;

    assign in_ready  = ~full_r;
    assign out_valid = ~empty_r;
    assign out_data  = mem[rp_r];
    assign push      = in_valid & ~full_r;
    assign pop       = out_ready & ~empty_r;

    // occupancy follows push and pop together
    always @* begin
        cnt_nxt = cnt_r;
        if (push & ~pop) cnt_nxt = cnt_r + 1'b1;
        if (pop & ~push) cnt_nxt = cnt_r - 1'b1;
    end

    // pointers and flags are flops so ready and valid never glitch
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r    <= {AW{1'b0}};
            rp_r    <= {AW{1'b0}};
            cnt_r   <= {(AW+1){1'b0}};
            full_r  <= 1'b0;
            empty_r <= 1'b1;
        end else begin
            if (push) wp_r <= wp_r + 1'b1;
            if (pop) rp_r <= rp_r + 1'b1;
            cnt_r   <= cnt_nxt;
            full_r  <= (cnt_nxt == DEPTH);
            empty_r <= (cnt_nxt == {(AW+1){1'b0}});
        end
    end

    // storage, no reset needed behind valid flags
    always @(posedge clk) begin
        if (push) mem[wp_r] <= in_data;
    end
endmodule // tcfl_fifo

// ----------------------------------------------------------------
// trace cache top, one per hardware thread
// ----------------------------------------------------------------
module tcfl_top (
    input  wire        clk,            // core clock, 100 MHz
    input  wire        rst,            // async reset, high
    input  wire        tc_enable,      // trace cache switched on
    input  wire        commit_valid,   // committed uop offered
    output wire        commit_ready,   // input fifo has room
    input  wire [31:0] commit_addr,    // address of this uop's macro
    input  wire [31:0] commit_seq,     // sequential next address
    input  wire [31:0] commit_tgt,     // taken target of a branch
    input  wire        commit_branch,  // uop is a branch
    input  wire        commit_dir,     // predicted direction, 1 taken
    input  wire        commit_first,   // first uop of its macro
    input  wire [7:0]  commit_mcount,  // uops in this macro
    input  wire [31:0] commit_uop,     // predecoded uop word
    input  wire        fetch_valid,    // fetch asks for a lookup
    input  wire [31:0] fetch_addr,     // instruction pointer
    input  wire [2:0]  pred_vec,       // multi-branch prediction
    output reg         fetch_busy_r,   // streaming, request ignored
    output reg         fetch_done_r,   // answer to a fetch request
    output reg         fetch_hit_r,    // trace supplies the fetch
    output reg  [31:0] next_fetch_r,   // next address after a hit
    output reg  [31:0] access_cnt_r,   // lookups performed
    output reg  [31:0] hit_cnt_r,      // lookups that matched
    output wire        tq_valid,       // uop for decode
    input  wire        tq_ready,       // decode takes the uop
    output wire [31:0] tq_uop          // uop to decode
);
    localparam CF_W = 32 * 4 + 8 + 3;
    integer i, j, k, m;

    // line store, private to this thread
    reg                     lv   [0:`TCFL_LINES-1];
    reg [`TCFL_ADDR_W-1:0]  ltag [0:`TCFL_LINES-1];
    reg [`TCFL_UCNT_W-1:0]  lucnt[0:`TCFL_LINES-1];
    reg [`TCFL_BCNT_W-1:0]  lbcnt[0:`TCFL_LINES-1];
    reg [`TCFL_MAX_BR-1:0]  ldir [0:`TCFL_LINES-1];
    reg [`TCFL_MAX_BR-1:0]  lmsk [0:`TCFL_LINES-1];
    reg [`TCFL_ADDR_W-1:0]  lseq [0:`TCFL_LINES-1];
    reg [`TCFL_ADDR_W-1:0]  ltgt [0:`TCFL_LINES-1];
    reg [1:0]               lage [0:`TCFL_LINES-1];
    reg [`TCFL_UOP_W-1:0]   umem [0:`TCFL_UMEM-1];

    // temporary trace of the fill unit
    reg [`TCFL_ADDR_W-1:0]  t_tag_r;
    reg [`TCFL_UCNT_W-1:0]  t_ucnt_r;
    reg [`TCFL_BCNT_W-1:0]  t_bcnt_r;
    reg [`TCFL_MAX_BR-1:0]  t_dir_r;
    reg [`TCFL_MAX_BR-1:0]  t_msk_r;
    reg [`TCFL_ADDR_W-1:0]  t_seq_r;
    reg [`TCFL_ADDR_W-1:0]  t_tgt_r;
    reg [`TCFL_UOP_W-1:0]   t_buf [0:`TCFL_MAX_UOPS-1];
    reg                     skip_r;

    // commit fifo output
    wire                    cf_valid;
    wire                    cf_ready;
    wire [CF_W-1:0]         cf_data;
    wire [31:0]             c_addr;
    wire [31:0]             c_seq;
    wire [31:0]             c_tgt;
    wire [31:0]             c_uop;
    wire [7:0]              c_mcnt;
    wire                    c_br;
    wire                    c_dir;
    wire                    c_first;

    // fill decisions
    wire                    t_empty;
    wire                    too_big;
    wire                    no_fit;
    wire                    dump_now;
    wire                    br_over;
    wire [`TCFL_SET_W-1:0]  f_set;
    reg  [`TCFL_WAY_W-1:0]  f_way;
    reg                     f_found;
    wire [`TCFL_LINE_W-1:0] f_idx;
    reg  [`TCFL_MAX_BR-1:0] d_dir;
    reg  [`TCFL_MAX_BR-1:0] d_msk;
    reg  [`TCFL_BCNT_W-1:0] d_bcnt;

    // lookup and stream
    reg                     st_r;
    reg                     st_nxt;
    wire                    tq_in_ready;
    wire                    do_look;
    wire [`TCFL_SET_W-1:0]  l_set;
    reg                     l_hit;
    reg  [`TCFL_WAY_W-1:0]  l_way;
    wire [`TCFL_LINE_W-1:0] l_idx;
    reg  [`TCFL_ADDR_W-1:0] l_next;
    reg  [`TCFL_LINE_W-1:0] s_idx_r;
    reg  [3:0]              s_pos_r;
    reg  [`TCFL_UCNT_W-1:0] s_len_r;
    wire                    s_push;
    wire                    s_last;

    // ------------------------------------------------------------
    // commit side buffering, only committed uops enter
    // ------------------------------------------------------------
    tcfl_fifo #(
        .WIDTH (CF_W),
        .DEPTH (`TCFL_CF_DEPTH),
        .AW    (`TCFL_CF_AW)
    ) u_cfifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (commit_valid),
        .in_ready  (commit_ready),
        .in_data   ({commit_addr, commit_seq, commit_tgt, commit_uop,
                     commit_mcount, commit_branch, commit_dir,
                     commit_first}),
        .out_valid (cf_valid),
        .out_ready (cf_ready),
        .out_data  (cf_data)
    );

    assign c_addr  = cf_data[CF_W-1 -: 32];
    assign c_seq   = cf_data[CF_W-33 -: 32];
    assign c_tgt   = cf_data[CF_W-65 -: 32];
    assign c_uop   = cf_data[CF_W-97 -: 32];
    assign c_mcnt  = cf_data[10:3];
    assign c_br    = cf_data[2];
    assign c_dir   = cf_data[1];
    assign c_first = cf_data[0];

    // ------------------------------------------------------------
    // fill unit fit checks
    // ------------------------------------------------------------
    // fit is judged per macro so its uops are never split
    assign t_empty = (t_ucnt_r == {`TCFL_UCNT_W{1'b0}});
    assign too_big = (c_mcnt > `TCFL_MAX_UOPS);
    assign no_fit  = ({3'h0, t_ucnt_r} + c_mcnt > `TCFL_MAX_UOPS)
                   | (t_bcnt_r == `TCFL_MAX_BR);
    // dump stalls the fifo one cycle, the uop is retried on empty trace
    assign dump_now = cf_valid & c_first & ~t_empty
                    & (no_fit | too_big);
    assign cf_ready = ~dump_now;
    // a macro holding several branches could overflow; drop the trace
    assign br_over = c_br & (t_bcnt_r == `TCFL_MAX_BR);
    assign f_set   = t_tag_r[`TCFL_SET_W-1:0];
    assign f_idx   = {f_set, f_way};

    // victim choice: invalid way first, else oldest age
    always @* begin
        f_way   = 2'h0;
        f_found = 1'b0;
        for (i = 0; i < `TCFL_WAYS; i = i + 1) begin
            if (!f_found && !lv[{f_set, i[1:0]}]) begin
                f_found = 1'b1;
                f_way   = i[1:0];
            end
        end
        for (i = 0; i < `TCFL_WAYS; i = i + 1) begin
            if (!f_found && lage[{f_set, i[1:0]}] == 2'h3) begin
                f_found = 1'b1;
                f_way   = i[1:0];
            end
        end
    end

    // a trailing branch leaves the direction match
    always @* begin
        d_dir  = t_dir_r;
        d_msk  = t_msk_r;
        d_bcnt = t_bcnt_r;
        if (t_tgt_r != 32'h0 && t_bcnt_r != 2'h0) begin
            d_dir[t_bcnt_r - 2'h1] = 1'b0;
            d_msk[t_bcnt_r - 2'h1] = 1'b0;
            d_bcnt = t_bcnt_r - 2'h1;
        end
    end

    // ------------------------------------------------------------
    // temporary trace building
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            t_tag_r  <= 32'h0;
            t_ucnt_r <= 5'h0;
            t_bcnt_r <= 2'h0;
            t_dir_r  <= 3'h0;
            t_msk_r  <= 3'h0;
            t_seq_r  <= 32'h0;
            t_tgt_r  <= 32'h0;
            skip_r   <= 1'b0;
        end else if (dump_now) begin
            t_ucnt_r <= 5'h0;
            t_bcnt_r <= 2'h0;
            t_dir_r  <= 3'h0;
            t_msk_r  <= 3'h0;
            t_tgt_r  <= 32'h0;
        end else if (cf_valid) begin
            if (c_first) skip_r <= too_big;
            if ((c_first & too_big) | (~c_first & skip_r)) begin
                t_ucnt_r <= t_ucnt_r;
            end else if (br_over) begin
                t_ucnt_r <= 5'h0;
                t_bcnt_r <= 2'h0;
                t_dir_r  <= 3'h0;
                t_msk_r  <= 3'h0;
                t_tgt_r  <= 32'h0;
                skip_r   <= 1'b1;
            end else begin
                if (t_empty) t_tag_r <= c_addr;
                t_seq_r  <= c_seq;
                t_ucnt_r <= t_ucnt_r + 5'h1;
                if (c_br) begin
                    t_tgt_r <= c_tgt;
                    t_dir_r[t_bcnt_r] <= c_dir;
                    t_msk_r[t_bcnt_r] <= 1'b1;
                    t_bcnt_r <= t_bcnt_r + 2'h1;
                end else begin
                    t_tgt_r <= 32'h0;
                end
            end
        end
    end

    // uop slots of the temporary trace
    always @(posedge clk) begin
        if (cf_valid & ~dump_now & ~(c_first & too_big)
            & ~(~c_first & skip_r) & ~br_over)
            t_buf[t_ucnt_r[3:0]] <= c_uop;
    end

    // ------------------------------------------------------------
    // lookup against fetch pointer and prediction
    // ------------------------------------------------------------
    // lookup only when enabled, idle and the queue has room
    assign do_look = fetch_valid & tc_enable & (st_r == `TCFL_ST_IDLE)
                   & tq_in_ready;
    assign l_set   = fetch_addr[`TCFL_SET_W-1:0];
    assign l_idx   = {l_set, l_way};

    // all ways compared at once; first matching way wins
    always @* begin
        l_hit = 1'b0;
        l_way = 2'h0;
        for (j = 0; j < `TCFL_WAYS; j = j + 1) begin
            if (!l_hit && lv[{l_set, j[1:0]}]
                && ltag[{l_set, j[1:0]}] == fetch_addr
                && (pred_vec & lmsk[{l_set, j[1:0]}])
                   == ldir[{l_set, j[1:0]}]) begin
                l_hit = 1'b1;
                l_way = j[1:0];
            end
        end
    end

    // next address: sequential unless trailing branch predicted taken
    always @* begin
        l_next = lseq[l_idx];
        if (ltgt[l_idx] != 32'h0 && pred_vec[lbcnt[l_idx]])
            l_next = ltgt[l_idx];
    end

    // ------------------------------------------------------------
    // line store writes and replacement ages
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            for (k = 0; k < `TCFL_LINES; k = k + 1) begin
                lv[k]   <= 1'b0;
                lage[k] <= 2'h3;
            end
        end else if (dump_now) begin
            lv[f_idx]    <= 1'b1;
            ltag[f_idx]  <= t_tag_r;
            lucnt[f_idx] <= t_ucnt_r;
            lbcnt[f_idx] <= d_bcnt;
            ldir[f_idx]  <= d_dir;
            lmsk[f_idx]  <= d_msk;
            lseq[f_idx]  <= t_seq_r;
            ltgt[f_idx]  <= t_tgt_r;
            // a same-cycle hit loses its age touch; fill is rarer
            for (k = 0; k < `TCFL_WAYS; k = k + 1) begin
                if (k[1:0] == f_way)
                    lage[{f_set, k[1:0]}] <= 2'h0;
                else if (lage[{f_set, k[1:0]}] <= lage[f_idx]
                         && lage[{f_set, k[1:0]}] != 2'h3)
                    lage[{f_set, k[1:0]}] <= lage[{f_set, k[1:0]}] + 2'h1;
            end
        end else if (do_look & l_hit) begin
            for (k = 0; k < `TCFL_WAYS; k = k + 1) begin
                if (k[1:0] == l_way)
                    lage[{l_set, k[1:0]}] <= 2'h0;
                else if (lage[{l_set, k[1:0]}] < lage[l_idx])
                    lage[{l_set, k[1:0]}] <= lage[{l_set, k[1:0]}] + 2'h1;
            end
        end
    end

    // copy the whole temporary trace into the line's uop slots
    always @(posedge clk) begin
        if (dump_now) begin
            for (m = 0; m < `TCFL_MAX_UOPS; m = m + 1)
                umem[{f_idx, m[3:0]}] <= t_buf[m];
        end
    end

    // ------------------------------------------------------------
    // fetch answer, statistics and trace streaming
    // ------------------------------------------------------------
    assign s_push = (st_r == `TCFL_ST_STREAM);
    assign s_last = ({1'b0, s_pos_r} == s_len_r - 5'h1);

    always @* begin
        st_nxt = st_r;
        case (st_r)
            `TCFL_ST_IDLE:   if (do_look & l_hit) st_nxt = `TCFL_ST_STREAM;
            `TCFL_ST_STREAM: if (tq_in_ready & s_last) st_nxt = `TCFL_ST_IDLE;
            default:         st_nxt = `TCFL_ST_IDLE;
        endcase
    end

    // every idle request is answered the next cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r         <= `TCFL_ST_IDLE;
            fetch_busy_r <= 1'b0;
            fetch_done_r <= 1'b0;
            fetch_hit_r  <= 1'b0;
            next_fetch_r <= 32'h0;
            access_cnt_r <= 32'h0;
            hit_cnt_r    <= 32'h0;
            s_idx_r      <= 8'h0;
            s_pos_r      <= 4'h0;
            s_len_r      <= 5'h0;
        end else begin
            st_r         <= st_nxt;
            fetch_busy_r <= (st_nxt == `TCFL_ST_STREAM);
            fetch_done_r <= fetch_valid & (st_r == `TCFL_ST_IDLE);
            fetch_hit_r  <= do_look & l_hit;
            if (do_look & l_hit) begin
                next_fetch_r <= l_next;
                s_idx_r      <= l_idx;
                s_pos_r      <= 4'h0;
                s_len_r      <= lucnt[l_idx];
            end
            if (do_look)
                access_cnt_r <= access_cnt_r + 32'h1;
            if (do_look & l_hit)
                hit_cnt_r <= hit_cnt_r + 32'h1;
            if (s_push & tq_in_ready)
                s_pos_r <= s_pos_r + 4'h1;
        end
    end

    // trace queue toward decode
    tcfl_fifo #(
        .WIDTH (`TCFL_UOP_W),
        .DEPTH (`TCFL_TQ_DEPTH),
        .AW    (`TCFL_TQ_AW)
    ) u_tqueue (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (s_push),
        .in_ready  (tq_in_ready),
        .in_data   (umem[{s_idx_r, s_pos_r}]),
        .out_valid (tq_valid),
        .out_ready (tq_ready),
        .out_data  (tq_uop)
    );
endmodule // tcfl_top

// *** tcfl_top_props.sv ***
// concurrent checks on the fetch side and trace queue ports of tcfl_top
// assumes one clock clk and async high reset rst; bound below
`timescale 1ns/10ps
module tcfl_props (
    input wire        clk,          // core clock
    input wire        rst,          // async reset, high
    input wire        tc_enable,    // cache on
    input wire        fetch_valid,  // lookup request
    input wire        fetch_busy_r, // streaming
    input wire        fetch_done_r, // answer pulse
    input wire        fetch_hit_r,  // hit pulse
    input wire [31:0] next_fetch_r, // next address
    input wire [31:0] access_cnt_r, // lookups
    input wire [31:0] hit_cnt_r,    // hits
    input wire        tq_valid,     // uop to decode
    input wire        tq_ready,     // decode takes
    input wire [31:0] tq_uop        // queue head
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // fetch answer
    // ----------------------------------------
    property p_hit_done; fetch_hit_r |-> fetch_done_r && fetch_busy_r; endproperty
    a_hit_done: assert property (p_hit_done) else $error("hit without done");
    property p_done_req; fetch_done_r |-> $past(fetch_valid); endproperty
    a_done_req: assert property (p_done_req) else $error("unasked answer");
    // a request during streaming must be dropped, not queued
    property p_busy_ign; fetch_valid && fetch_busy_r |=> !fetch_done_r; endproperty
    a_busy_ign: assert property (p_busy_ign) else $error("busy answered");
    property p_next_hold; !fetch_hit_r |-> $stable(next_fetch_r); endproperty
    a_next_hold: assert property (p_next_hold) else $error("next moved");
    property p_hit_en; fetch_hit_r |-> $past(tc_enable); endproperty
    a_hit_en: assert property (p_hit_en) else $error("hit while off");
    // ----------------------------------------
    // counters and queue
    // ----------------------------------------
    property p_acc_step;
        access_cnt_r != $past(access_cnt_r) |-> fetch_done_r && $past(tc_enable)
            && access_cnt_r == $past(access_cnt_r) + 32'h1;
    endproperty
    a_acc_step: assert property (p_acc_step) else $error("access step");
    property p_hit_cnt; hit_cnt_r == $past(hit_cnt_r) + {31'h0, fetch_hit_r}; endproperty
    a_hit_cnt: assert property (p_hit_cnt) else $error("hit count");
    property p_tq_hold; tq_valid && !tq_ready |=> tq_valid && $stable(tq_uop); endproperty
    a_tq_hold: assert property (p_tq_hold) else $error("queue head lost");
    c_hit: cover property (fetch_hit_r);
    c_miss: cover property (fetch_done_r && !fetch_hit_r);
    c_stall: cover property (fetch_busy_r && tq_valid && !tq_ready);
endmodule // tcfl_props

bind tcfl_top tcfl_props u_props (.clk(clk), .rst(rst), .tc_enable(tc_enable),
    .fetch_valid(fetch_valid), .fetch_busy_r(fetch_busy_r),
    .fetch_done_r(fetch_done_r), .fetch_hit_r(fetch_hit_r),
    .next_fetch_r(next_fetch_r), .access_cnt_r(access_cnt_r),
    .hit_cnt_r(hit_cnt_r), .tq_valid(tq_valid), .tq_ready(tq_ready),
    .tq_uop(tq_uop));

// *** tcfl_decode_model.sv ***
// decode side consumer of the trace queue
// assumes valid/ready taken on the rising clk edge
`timescale 1ns/10ps
module tcfl_decode_model (
    input  wire        clk,      // core clock
    input  wire        rst,      // async reset, high
    input  wire        tq_valid, // uop offered
    input  wire [31:0] tq_uop,   // uop word
    output logic       tq_ready  // uop taken
);
    logic [1:0] ph_r; // stall phase
    int         got;  // uops taken so far
    // a stall every third cycle keeps back-pressure on the stream
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_r     <= 2'h0;
            got      <= 0;
            tq_ready <= 1'b0;
        end else begin
            ph_r     <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
            tq_ready <= (ph_r != 2'h1);
            if (tq_valid && tq_ready)
                got <= got + 1;
        end
    end
endmodule // tcfl_decode_model

// *** tcfl_tb.sv ***
// self-checking bench: fills traces from commits, then looks them up
// assumes tcfl_decode_model on the queue and the bound checker
`timescale 1ns/10ps
module testbench;
    logic        clk = 1'b0, rst = 1'b1, tc_enable = 1'b0, fetch_valid = 1'b0;
    logic        commit_valid = 1'b0, commit_branch = 1'b0, commit_dir = 1'b0;
    logic        commit_first = 1'b0;
    logic [31:0] commit_addr = 32'h0, commit_seq = 32'h0, commit_tgt = 32'h0;
    logic [31:0] commit_uop = 32'h0, fetch_addr = 32'h0;
    logic [7:0]  commit_mcount = 8'h0;
    logic [2:0]  pred_vec = 3'h0;
    wire         commit_ready, fetch_busy_r, fetch_done_r, fetch_hit_r;
    wire         tq_valid, tq_ready;
    wire [31:0]  next_fetch_r, access_cnt_r, hit_cnt_r, tq_uop;
    int          fails = 0, checked = 0, n_acc = 0, n_hit = 0;

    always #5 clk = ~clk;

    tcfl_top dut (.clk(clk), .rst(rst), .tc_enable(tc_enable),
        .commit_valid(commit_valid), .commit_ready(commit_ready),
        .commit_addr(commit_addr), .commit_seq(commit_seq),
        .commit_tgt(commit_tgt), .commit_branch(commit_branch),
        .commit_dir(commit_dir), .commit_first(commit_first),
        .commit_mcount(commit_mcount), .commit_uop(commit_uop),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
        .pred_vec(pred_vec), .fetch_busy_r(fetch_busy_r),
        .fetch_done_r(fetch_done_r), .fetch_hit_r(fetch_hit_r),
        .next_fetch_r(next_fetch_r), .access_cnt_r(access_cnt_r),
        .hit_cnt_r(hit_cnt_r), .tq_valid(tq_valid), .tq_ready(tq_ready),
        .tq_uop(tq_uop));
    tcfl_decode_model model (.clk(clk), .rst(rst), .tq_valid(tq_valid),
        .tq_uop(tq_uop), .tq_ready(tq_ready));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic print_verdict;
        if (fails == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic c, input string m);
        checked++;
        if (c !== 1'b1) begin fails++; $display("BAD %0t %s", $time, m); end
    endtask
    task automatic tmo;
        fails++;
        $display("BAD %0t wait ran out", $time);
        print_verdict();
    endtask
    // one uop; valid stays up so a macro goes out back to back
    task automatic com(input [31:0] a, t, input br, dr, fi, input [7:0] mc, u);
        int i;
        commit_valid <= 1'b1; commit_addr <= a; commit_seq <= a + 32'h4;
        commit_tgt <= t; commit_branch <= br; commit_dir <= dr;
        commit_first <= fi; commit_mcount <= mc; commit_uop <= a + {24'h0, u};
        @(negedge clk);
        for (i = 0; i < 50 && commit_ready !== 1'b1; i++) @(negedge clk);
        if (i == 50) tmo();
        @(posedge clk);
    endtask
    task automatic mac(input [31:0] a, input [7:0] n, input br, dr, input [31:0] t);
        logic [7:0] k;
        for (k = 8'h0; k < n; k++)
            com(a, (br && k == n - 8'h1) ? t : 32'h0, br && k == n - 8'h1, dr, k == 8'h0, n, k);
    endtask
    // one lookup: answer, counters, next address and streamed length
    task automatic lk(input [31:0] a, input [2:0] p, input eh, input [31:0] en, input int eu);
        int i, g0;
        logic [31:0] hd = 32'h0;
        g0 = model.got;
        @(posedge clk);
        fetch_valid <= 1'b1; fetch_addr <= a; pred_vec <= p;
        @(posedge clk);
        // a hit keeps asking one more edge: streaming must ignore it
        fetch_valid <= eh;
        #1;
        for (i = 0; i < 4 && fetch_done_r !== 1'b1; i++) begin @(posedge clk); #1; end
        if (i == 4) tmo();
        if (tc_enable) n_acc++;
        if (eh) n_hit++;
        chk(fetch_hit_r === eh, "hit flag");
        for (i = 0; i < 200 && (fetch_busy_r !== 1'b0 || tq_valid !== 1'b0); i++) begin
            @(posedge clk);
            fetch_valid <= 1'b0;
            #1;
            if (hd == 32'h0 && tq_valid === 1'b1) hd = tq_uop;
        end
        if (i == 200) tmo();
        chk(access_cnt_r === n_acc && hit_cnt_r === n_hit, "counters");
        if (eh) chk(next_fetch_r === en && model.got - g0 == eu, "next or length");
        if (eh) chk(hd === a, "trace head");
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic sc_reset;
        @(posedge clk); #1;
        chk(commit_ready === 1'b1 && tq_valid === 1'b0 && access_cnt_r === 32'h0, "reset");
    endtask
    // traces at 0x100, 0x140 and 0x1c0 end up stored; 0x280 is oversized
    task automatic sc_fill;
        @(posedge clk);
        mac(32'h100, 8'h1, 1'b1, 1'b1, 32'h200);
        mac(32'h200, 8'h1, 1'b0, 1'b0, 32'h0);
        mac(32'h140, 8'hf, 1'b0, 1'b0, 32'h0);
        mac(32'h180, 8'h1, 1'b1, 1'b0, 32'h1c0);
        mac(32'h1c0, 8'h1, 1'b0, 1'b0, 32'h0);
        mac(32'h280, 8'h11, 1'b0, 1'b0, 32'h0);
        mac(32'h2c0, 8'h1, 1'b0, 1'b0, 32'h0);
        commit_valid <= 1'b0;
        repeat (10) @(posedge clk);
    endtask
    task automatic sc_disabled;
        lk(32'h100, 3'h1, 1'b0, 32'h0, 0);
        @(posedge clk);
        tc_enable <= 1'b1;
    endtask
    task automatic sc_match;
        lk(32'h100, 3'h0, 1'b0, 32'h0, 0);
        lk(32'h100, 3'h1, 1'b1, 32'h204, 2);
    endtask
    task automatic sc_target;
        lk(32'h140, 3'h1, 1'b1, 32'h1c0, 16);
        lk(32'h140, 3'h0, 1'b1, 32'h184, 16);
    endtask
    task automatic sc_limits;
        lk(32'h1c0, 3'h0, 1'b1, 32'h1c4, 1);
        lk(32'h280, 3'h0, 1'b0, 32'h0, 0);
        lk(32'h2c0, 3'h0, 1'b0, 32'h0, 0);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        sc_reset();
        sc_fill();
        sc_disabled();
        sc_match();
        sc_target();
        sc_limits();
        print_verdict();
    end
endmodule // testbench
